/* File: engine_ctrl_pkg.sv */
package engine_ctrl_pkg;

  // Bank select carried with each register access
  localparam logic BANK_CONFIG  = 1'b0;
  localparam logic BANK_CONTROL = 1'b1;

  // Configuration bank indices held by this block
  localparam logic [3:0] CFG_IGN_PREDRIVER_IDX = 4'h8;
  localparam logic [3:0] CFG_UNUSED_NINE_IDX   = 4'h9;
  localparam logic [3:0] CFG_WATCHDOG_IDX      = 4'hA;
  localparam logic [3:0] CFG_VRS_RUNNING_IDX   = 4'hB;
  localparam logic [3:0] CFG_VRS_AUTO_IDX      = 4'hC;
  localparam logic [3:0] CFG_VRS_MISC_IDX      = 4'hD;

  // Control bank indices
  localparam logic [3:0] CTL_SWITCHES_IDX      = 4'h0;
  localparam logic [3:0] CTL_AUX_IDX           = 4'h1;
  localparam logic [3:0] CTL_INJECTOR_IDX      = 4'h2;
  localparam logic [3:0] CTL_UNUSED_THREE_IDX  = 4'h3;
  localparam logic [3:0] CTL_FUEL_PUMP_IDX     = 4'h4;
  localparam logic [3:0] CTL_POWER_RELAY_IDX   = 4'h5;
  localparam logic [3:0] CTL_TACH_IDX          = 4'h6;
  localparam logic [3:0] CTL_LAMP_IDX          = 4'h7;
  localparam logic [3:0] CTL_BATTERY_SW_IDX    = 4'h8;
  localparam logic [3:0] CTL_HEATER_IDX        = 4'h9;
  localparam logic [3:0] CTL_IGN_DUTY_IDX      = 4'hA;
  localparam logic [3:0] CTL_UNUSED_ELEVEN_IDX = 4'hB;
  localparam logic [3:0] CTL_WATCHDOG_IDX      = 4'hC;
  localparam logic [3:0] CTL_VRS_CRANK_IDX     = 4'hD;

  // Field positions
  localparam int IGN_GND_SEL_BIT    = 7;
  localparam int IGN_RETRY_BIT      = 6;
  localparam int IGN_OL_SINK_BIT    = 4;
  localparam int IGN_COMBINE_BIT    = 2;
  localparam int AUX_POWER_ON_SELF_CHECK_BIT       = 6;
  localparam int AUX_VPROT_BIT      = 4;
  localparam int AUX_BATSW_BIT      = 2;
  localparam int AUX_TACH_BIT       = 1;
  localparam int AUX_SOFT_RESET_BIT = 0;
  localparam int WD_REFRESH_BIT     = 7;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Writable bits per index, index 15 first; zero bits read as zero
  localparam logic [15:0][7:0] CFG_MASKS = {
    8'h00, 8'h00, 8'hDF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hD7,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [15:0][7:0] CTL_MASKS = {
    8'h00, 8'h00, 8'hFF, 8'h7F, 8'h00, 8'h7F, 8'h7F, 8'h7F,
    8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h00, 8'h7F, 8'h56, 8'hFF};

  typedef struct packed {
    logic       bank;
    logic [3:0] index;
    logic       wr;
    logic       rd;
    logic [7:0] data;
  } reg_req_type;

  typedef struct packed {
    logic       injector_enable;
    logic       second_injector_enable;
    logic       fuel_pump_relay_enable;
    logic       power_relay_enable;
    logic       lamp_enable;
    logic       first_ignition_enable;
    logic       second_ignition_enable;
    logic       oxygen_heater_enable;
  } switch_type;

  typedef struct packed {
    logic       ground_driver_select;
    logic       retry_enable;
    logic       open_load_sink;
    logic       or_and_combine;
    logic [1:0] pwm_freq;
  } ign_cfg_type;

  typedef struct packed {
    logic [3:0] threshold;
    logic [3:0] filter_time;
  } vrs_cfg_type;

  typedef struct packed {
    logic [7:0] value;
  } byte_state_type;

  typedef struct packed {
    logic [7:0] rd_data;
    logic       refresh;
    logic       soft_reset;
  } bank_state_type;

endpackage

/* File: masked_byte_reg.sv */
`timescale 1ns/100ps
module masked_byte_reg #(
  parameter logic [7:0] MASK = 8'hFF
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Write side
  input  wire logic       wr,
  input  wire logic [7:0] wr_data,
  // Stored value
  output logic [7:0]      q
);

  engine_ctrl_pkg::byte_state_type state_r;
  engine_ctrl_pkg::byte_state_type state_nxt;

  // Masked bits never store, so they read back as zero
  always_comb begin
    state_nxt = state_r;
    if (wr) begin
      state_nxt.value = wr_data & MASK;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= engine_ctrl_pkg::REG_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign q = state_r.value;

endmodule // masked_byte_reg

/* File: engine_ctrl_regs.sv */
`timescale 1ns/100ps
// How it works
// - Config index 8 keeps ground select, retry, sink, combine and PWM freq.
// - Unused indices and reserved bits read zero and ignore writes.
// - Non-writable bits drop written values and always read zero.
// - Control index 13 holds the crank threshold and filter codes.
// - Duty registers 2 and 4 to 10 keep a 7-bit code with bit 7 reading zero.
// - Watchdog refresh fires only on a written one and reads back zero.
module engine_ctrl_regs (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  // Register access from the serial front end
  input  wire engine_ctrl_pkg::reg_req_type req,
  output logic [7:0]                        rd_data,
  // Driver switches
  output engine_ctrl_pkg::switch_type       switches,
  output logic                              power_on_self_check_enable,
  output logic                              vprot_enable,
  output logic                              batsw_enable,
  output logic                              tach_enable,
  output logic                              internal_reset,
  // Duty codes
  output logic [6:0]                        injector_duty,
  output logic [6:0]                        fuel_pump_relay_duty,
  output logic [6:0]                        power_relay_duty,
  output logic [6:0]                        tachometer_duty,
  output logic [6:0]                        warning_lamp_duty,
  output logic [6:0]                        battery_switch_duty,
  output logic [6:0]                        heater_predriver_duty,
  output logic [6:0]                        ignition_predriver_duty,
  // Configuration
  output engine_ctrl_pkg::ign_cfg_type      ign_cfg,
  output logic [7:0]                        watchdog_settings,
  output engine_ctrl_pkg::vrs_cfg_type      vrs_running,
  output logic [7:0]                        vrs_automatic,
  output logic [7:0]                        vrs_misc,
  // Watchdog and cranking control
  output logic [6:0]                        watchdog_load,
  output logic                              watchdog_refresh,
  output engine_ctrl_pkg::vrs_cfg_type      vrs_cranking
);

  logic [15:0][7:0] cfg_q;
  logic [15:0][7:0] ctl_q;
  engine_ctrl_pkg::bank_state_type state_r;
  engine_ctrl_pkg::bank_state_type state_nxt;
  logic ctl_wr;

  assign ctl_wr = req.wr && (req.bank == engine_ctrl_pkg::BANK_CONTROL);

  // Reserved bits are masked at the store, not at the read
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_reg
      masked_byte_reg #(
        .MASK (engine_ctrl_pkg::CFG_MASKS[i])
      ) u_cfg (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr      (req.wr && req.bank == engine_ctrl_pkg::BANK_CONFIG
                  && req.index == 4'(i)),
        .wr_data (req.data),
        .q       (cfg_q[i])
      );
      masked_byte_reg #(
        .MASK (engine_ctrl_pkg::CTL_MASKS[i])
      ) u_ctl (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr      (ctl_wr && req.index == 4'(i)),
        .wr_data (req.data),
        .q       (ctl_q[i])
      );
    end
  endgenerate

  always_comb begin
    state_nxt            = state_r;
    state_nxt.refresh    = 1'b0;
    state_nxt.soft_reset = 1'b0;
    if (req.rd) begin
      state_nxt.rd_data = (req.bank == engine_ctrl_pkg::BANK_CONTROL)
                          ? ctl_q[req.index] : cfg_q[req.index];
    end
    // Pulses are not stored, so these bits read back zero
    if (ctl_wr && req.index == engine_ctrl_pkg::CTL_WATCHDOG_IDX) begin
      state_nxt.refresh =
        req.data[engine_ctrl_pkg::WD_REFRESH_BIT];
    end
    if (ctl_wr && req.index == engine_ctrl_pkg::CTL_AUX_IDX) begin
      state_nxt.soft_reset =
        req.data[engine_ctrl_pkg::AUX_SOFT_RESET_BIT];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rd_data          = state_r.rd_data;
  assign watchdog_refresh = state_r.refresh;
  assign internal_reset   = state_r.soft_reset;

  assign switches = engine_ctrl_pkg::switch_type'(
    ctl_q[engine_ctrl_pkg::CTL_SWITCHES_IDX]);
  assign power_on_self_check_enable  =
    ctl_q[engine_ctrl_pkg::CTL_AUX_IDX][engine_ctrl_pkg::AUX_POWER_ON_SELF_CHECK_BIT];
  assign vprot_enable =
    ctl_q[engine_ctrl_pkg::CTL_AUX_IDX][engine_ctrl_pkg::AUX_VPROT_BIT];
  assign batsw_enable =
    ctl_q[engine_ctrl_pkg::CTL_AUX_IDX][engine_ctrl_pkg::AUX_BATSW_BIT];
  assign tach_enable  =
    ctl_q[engine_ctrl_pkg::CTL_AUX_IDX][engine_ctrl_pkg::AUX_TACH_BIT];

  assign injector_duty  = ctl_q[engine_ctrl_pkg::CTL_INJECTOR_IDX][6:0];
  assign fuel_pump_relay_duty =
    ctl_q[engine_ctrl_pkg::CTL_FUEL_PUMP_IDX][6:0];
  assign power_relay_duty =
    ctl_q[engine_ctrl_pkg::CTL_POWER_RELAY_IDX][6:0];
  assign tachometer_duty    = ctl_q[engine_ctrl_pkg::CTL_TACH_IDX][6:0];
  assign warning_lamp_duty  = ctl_q[engine_ctrl_pkg::CTL_LAMP_IDX][6:0];
  assign battery_switch_duty =
    ctl_q[engine_ctrl_pkg::CTL_BATTERY_SW_IDX][6:0];
  assign heater_predriver_duty =
    ctl_q[engine_ctrl_pkg::CTL_HEATER_IDX][6:0];
  assign ignition_predriver_duty =
    ctl_q[engine_ctrl_pkg::CTL_IGN_DUTY_IDX][6:0];

  assign ign_cfg = engine_ctrl_pkg::ign_cfg_type'({
    cfg_q[engine_ctrl_pkg::CFG_IGN_PREDRIVER_IDX][7:6],
    cfg_q[engine_ctrl_pkg::CFG_IGN_PREDRIVER_IDX][4],
    cfg_q[engine_ctrl_pkg::CFG_IGN_PREDRIVER_IDX][2:0]});
  assign watchdog_settings = cfg_q[engine_ctrl_pkg::CFG_WATCHDOG_IDX];
  assign vrs_running = engine_ctrl_pkg::vrs_cfg_type'(
    cfg_q[engine_ctrl_pkg::CFG_VRS_RUNNING_IDX]);
  assign vrs_automatic = cfg_q[engine_ctrl_pkg::CFG_VRS_AUTO_IDX];
  assign vrs_misc      = cfg_q[engine_ctrl_pkg::CFG_VRS_MISC_IDX];

  assign watchdog_load = ctl_q[engine_ctrl_pkg::CTL_WATCHDOG_IDX][6:0];
  assign vrs_cranking  = engine_ctrl_pkg::vrs_cfg_type'(
    ctl_q[engine_ctrl_pkg::CTL_VRS_CRANK_IDX]);

  property p_ign_fields;
    @(posedge clk) disable iff (sys_rst)
    (req.wr && req.bank == engine_ctrl_pkg::BANK_CONFIG
     && req.index == engine_ctrl_pkg::CFG_IGN_PREDRIVER_IDX)
    |=> (ign_cfg.ground_driver_select == $past(req.data[7]))
        && (ign_cfg.retry_enable == $past(req.data[6]))
        && (ign_cfg.open_load_sink == $past(req.data[4]))
        && (ign_cfg.or_and_combine == $past(req.data[2]))
        && (ign_cfg.pwm_freq == $past(req.data[1:0]));
  endproperty
  a_ign_fields: assert property (p_ign_fields)
    else $error("ignition config fields wrong after write");

  property p_unused_zero;
    @(posedge clk) disable iff (sys_rst)
    (req.rd && ((req.bank == engine_ctrl_pkg::BANK_CONFIG
       && req.index == engine_ctrl_pkg::CFG_UNUSED_NINE_IDX)
     || (req.bank == engine_ctrl_pkg::BANK_CONTROL
       && (req.index == engine_ctrl_pkg::CTL_UNUSED_THREE_IDX
        || req.index == engine_ctrl_pkg::CTL_UNUSED_ELEVEN_IDX))))
    |=> rd_data == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused register read non-zero");

  property p_nonwrite_zero;
    @(posedge clk) disable iff (sys_rst)
    (req.rd && req.bank == engine_ctrl_pkg::BANK_CONTROL
     && req.index == engine_ctrl_pkg::CTL_AUX_IDX)
    |=> (rd_data & 8'hA9) == 8'h00;
  endproperty
  a_nonwrite_zero: assert property (p_nonwrite_zero)
    else $error("non-writable auxiliary bit read non-zero");

  property p_crank_store;
    @(posedge clk) disable iff (sys_rst)
    (ctl_wr && req.index == engine_ctrl_pkg::CTL_VRS_CRANK_IDX)
    |=> vrs_cranking == $past(req.data);
  endproperty
  a_crank_store: assert property (p_crank_store)
    else $error("cranking settings not stored");

  // A read in the write's own cycle would still see the old value,
  // so the readback is taken two cycles after the write
  property p_duty_store;
    @(posedge clk) disable iff (sys_rst)
    (ctl_wr && req.index == engine_ctrl_pkg::CTL_INJECTOR_IDX)
    ##1 !(ctl_wr && req.index == engine_ctrl_pkg::CTL_INJECTOR_IDX)
    ##1 (req.rd && req.bank == engine_ctrl_pkg::BANK_CONTROL
         && req.index == engine_ctrl_pkg::CTL_INJECTOR_IDX)
    |=> rd_data == {1'b0, $past(req.data[6:0], 3)};
  endproperty
  a_duty_store: assert property (p_duty_store)
    else $error("duty readback wrong or bit 7 set");

  property p_duty_bit7;
    @(posedge clk) disable iff (sys_rst)
    (req.rd && req.bank == engine_ctrl_pkg::BANK_CONTROL
     && req.index >= engine_ctrl_pkg::CTL_INJECTOR_IDX
     && req.index <= engine_ctrl_pkg::CTL_IGN_DUTY_IDX)
    |=> !rd_data[7];
  endproperty
  a_duty_bit7: assert property (p_duty_bit7)
    else $error("duty register bit 7 read non-zero");

  property p_refresh_pulse;
    @(posedge clk) disable iff (sys_rst)
    (ctl_wr && req.index == engine_ctrl_pkg::CTL_WATCHDOG_IDX)
    |=> watchdog_refresh
        == $past(req.data[engine_ctrl_pkg::WD_REFRESH_BIT]);
  endproperty
  a_refresh_pulse: assert property (p_refresh_pulse)
    else $error("refresh pulse does not follow written bit");

  property p_refresh_idle;
    @(posedge clk) disable iff (sys_rst)
    !(ctl_wr && req.index == engine_ctrl_pkg::CTL_WATCHDOG_IDX
      && req.data[engine_ctrl_pkg::WD_REFRESH_BIT])
    |=> !watchdog_refresh;
  endproperty
  a_refresh_idle: assert property (p_refresh_idle)
    else $error("refresh pulse without a written one");

  property p_refresh_read_zero;
    @(posedge clk) disable iff (sys_rst)
    (req.rd && req.bank == engine_ctrl_pkg::BANK_CONTROL
     && req.index == engine_ctrl_pkg::CTL_WATCHDOG_IDX)
    |=> !rd_data[engine_ctrl_pkg::WD_REFRESH_BIT];
  endproperty
  a_refresh_read_zero: assert property (p_refresh_read_zero)
    else $error("refresh bit read back non-zero");

  property p_soft_reset_pulse;
    @(posedge clk) disable iff (sys_rst)
    (ctl_wr && req.index == engine_ctrl_pkg::CTL_AUX_IDX)
    |=> internal_reset
        == $past(req.data[engine_ctrl_pkg::AUX_SOFT_RESET_BIT]);
  endproperty
  a_soft_reset_pulse: assert property (p_soft_reset_pulse)
    else $error("internal reset pulse does not follow written bit");

  property p_switch_drive;
    @(posedge clk) disable iff (sys_rst)
    (ctl_wr && req.index == engine_ctrl_pkg::CTL_SWITCHES_IDX)
    |=> switches == $past(req.data);
  endproperty
  a_switch_drive: assert property (p_switch_drive)
    else $error("driver switches do not follow written value");

  property p_switch_hold;
    @(posedge clk) disable iff (sys_rst)
    !(ctl_wr && req.index == engine_ctrl_pkg::CTL_SWITCHES_IDX)
    |=> $stable(switches);
  endproperty
  a_switch_hold: assert property (p_switch_hold)
    else $error("driver switches changed without a write");

endmodule // engine_ctrl_regs

/* File: host_model.sv */
`timescale 1ns/100ps
module host_model (
  // Clock
  input  wire logic                    clk,
  // Register access toward the device
  output engine_ctrl_pkg::reg_req_type req,
  input  wire logic [7:0]              rd_data
);
  logic [7:0] last_data;

  initial begin
    req = '0;
    last_data = 8'h00;
  end

  // One access, then a released cycle; idle lines wander so stale data
  // never looks valid
  task automatic access(input logic bank, input logic [3:0] idx,
                        input logic wr, input logic [7:0] data,
                        output logic [7:0] seen);
    @(negedge clk);
    req <= '{bank: bank, index: idx, wr: wr, rd: !wr, data: data};
    last_data = data;
    @(negedge clk);
    seen = rd_data;
    req <= '{bank: ~bank, index: ~idx, wr: 1'b0, rd: 1'b0,
             data: ~last_data};
  endtask

  // Refresh is only ever asked for with a written one
  task automatic refresh(input logic [6:0] load);
    logic [7:0] unused;
    access(1'b1, 4'hC, 1'b1, {1'b1, load}, unused);
  endtask
endmodule // host_model

/* File: engine_ctrl_spi_register_map_tb_top.sv */
`timescale 1ns/100ps
module engine_ctrl_spi_register_map_tb_top;
  logic                         clk = 1'b0;
  logic                         sys_rst = 1'b1;
  engine_ctrl_pkg::reg_req_type req;
  logic [7:0]                   rd_data, seen, d, wd_set, vrs_auto, vrs_misc;
  engine_ctrl_pkg::switch_type  switches;
  engine_ctrl_pkg::ign_cfg_type ign_cfg;
  engine_ctrl_pkg::vrs_cfg_type vrs_running, vrs_cranking;
  logic                         power_on_self_check_en, vprot_en, batsw_en, tach_en, wd_rfsh;
  logic [6:0]                   inj, fuel, pwr, tach, lamp, bat, heat, ign;
  logic [6:0]                   wd_load;
  logic                         soft_rst;
  logic [31:0]                  seed = 32'h2B26;
  int                           miscompares = 0;
  int                           checked = 0;

  always #25 clk = ~clk;

  host_model host (.clk(clk), .req(req), .rd_data(rd_data));

  engine_ctrl_regs uut (
    .clk(clk), .sys_rst(sys_rst), .req(req), .rd_data(rd_data),
    .switches(switches), .power_on_self_check_enable(power_on_self_check_en), .vprot_enable(vprot_en),
    .batsw_enable(batsw_en), .tach_enable(tach_en),
    .internal_reset(soft_rst),
    .injector_duty(inj), .fuel_pump_relay_duty(fuel),
    .power_relay_duty(pwr), .tachometer_duty(tach),
    .warning_lamp_duty(lamp), .battery_switch_duty(bat),
    .heater_predriver_duty(heat), .ignition_predriver_duty(ign),
    .ign_cfg(ign_cfg), .watchdog_settings(wd_set),
    .vrs_running(vrs_running), .vrs_automatic(vrs_auto),
    .vrs_misc(vrs_misc), .watchdog_load(wd_load),
    .watchdog_refresh(wd_rfsh), .vrs_cranking(vrs_cranking));

  function automatic logic [31:0] lfsr(logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Bits that keep a written value; all others read zero
  function automatic logic [7:0] exp_mask(logic bank, logic [3:0] idx);
    exp_mask = 8'h00;
    if (!bank) begin
      if (idx == 4'h8) exp_mask = 8'hD7;
      if (idx inside {4'hA, 4'hB, 4'hC}) exp_mask = 8'hFF;
      if (idx == 4'hD) exp_mask = 8'hDF;
    end else begin
      if (idx inside {4'h0, 4'hD}) exp_mask = 8'hFF;
      if (idx == 4'h1) exp_mask = 8'h56;
      if (idx inside {[4'h2:4'hA], 4'hC} && idx != 4'h3) exp_mask = 8'h7F;
    end
  endfunction

  // Output ports regathered into register bit order
  function automatic logic [7:0] port_view(logic bank, logic [3:0] idx);
    case ({bank, idx})
      5'h08: port_view = {ign_cfg[5:4], 1'b0, ign_cfg[3], 1'b0, ign_cfg[2:0]};
      5'h0A: port_view = wd_set;
      5'h0B: port_view = vrs_running;
      5'h0C: port_view = vrs_auto;
      5'h0D: port_view = vrs_misc;
      5'h10: port_view = switches;
      5'h11: port_view = {1'b0, power_on_self_check_en, 1'b0, vprot_en, 1'b0, batsw_en,
                          tach_en, 1'b0};
      5'h12: port_view = {1'b0, inj};
      5'h14: port_view = {1'b0, fuel};
      5'h15: port_view = {1'b0, pwr};
      5'h16: port_view = {1'b0, tach};
      5'h17: port_view = {1'b0, lamp};
      5'h18: port_view = {1'b0, bat};
      5'h19: port_view = {1'b0, heat};
      5'h1A: port_view = {1'b0, ign};
      5'h1C: port_view = {1'b0, wd_load};
      5'h1D: port_view = vrs_cranking;
      default: port_view = 8'h00;
    endcase
  endfunction

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    for (int a = 0; a < 32; a++) begin
      host.access(a[4], a[3:0], 1'b0, 8'h00, seen);
      check("reset read", 8'h00, seen);
      check("reset port", 8'h00, port_view(a[4], a[3:0]));
    end
    // All ones, all zeros, then random bytes into every place
    for (int p = 0; p < 5; p++) begin
      for (int a = 0; a < 32; a++) begin
        seed = lfsr(seed);
        d = (p == 0) ? 8'hFF : (p == 1) ? 8'h00 : seed[7:0];
        host.access(a[4], a[3:0], 1'b1, d, seen);
        d = d & exp_mask(a[4], a[3:0]);
        check("port", d, port_view(a[4], a[3:0]));
        host.access(a[4], a[3:0], 1'b0, 8'h00, seen);
        check("readback", d, seen);
      end
    end
    host.refresh(7'h05);
    check("refresh pulse", 8'h01, {7'h00, wd_rfsh});
    check("watchdog load", 8'h05, {1'b0, wd_load});
    @(negedge clk);
    check("refresh end", 8'h00, {7'h00, wd_rfsh});
    host.access(1'b1, 4'hC, 1'b1, 8'h2A, seen);
    check("refresh on zero", 8'h00, {7'h00, wd_rfsh});
    host.access(1'b1, 4'hC, 1'b0, 8'h00, seen);
    check("refresh readback", 8'h2A, seen);
    // Internal reset is a write-only one-cycle pulse
    host.access(1'b1, 4'h1, 1'b1, 8'h01, seen);
    check("reset pulse", 8'h01, {7'h00, soft_rst});
    @(negedge clk);
    check("reset pulse end", 8'h00, {7'h00, soft_rst});
    host.access(1'b1, 4'h1, 1'b1, 8'h56, seen);
    check("reset on zero", 8'h00, {7'h00, soft_rst});
    host.access(1'b1, 4'h1, 1'b0, 8'h00, seen);
    check("aux readback", 8'h56, seen);
    tally_and_finish();
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule // engine_ctrl_spi_register_map_tb_top
